// >>> hdl/aic_pkg.sv
package aic_pkg;
    // Result word and buffer geometry.
    localparam int          SMP_W        = 20;
    localparam int          BUF_AW       = 14;
    localparam logic [14:0] BUF_DEPTH    = 15'h4000;
    localparam logic [4:0]  WORD_BITS    = 5'h14;
    // APB register byte offsets.
    localparam logic [7:0]  A_OFFSET     = 8'h00;
    localparam logic [7:0]  A_GAIN       = 8'h04;
    localparam logic [7:0]  A_PATTERN    = 8'h08;
    localparam logic [7:0]  A_STATUS     = 8'h0C;
    localparam logic [19:0] OFFSET_RST   = 20'h0_0000;
    localparam logic [15:0] GAIN_RST     = 16'h8000;
    localparam logic [19:0] PATTERN_RST  = 20'hA_5A5A;
    // Configuration port register addresses.
    localparam logic [14:0] CR_IFA       = 15'h0000;
    localparam logic [14:0] CR_PATH      = 15'h0014;
    localparam logic [14:0] CR_LANE      = 15'h0015;
    localparam logic [14:0] CR_DIFB      = 15'h0016;
    localparam logic [14:0] CR_FILT      = 15'h0017;
    localparam logic [14:0] CR_GPIO      = 15'h001E;
    localparam logic [7:0]  CR_IFA_RST   = 8'h00;
    localparam logic [7:0]  CR_PATH_RST  = 8'h00;
    localparam logic [7:0]  CR_LANE_RST  = 8'h00;
    localparam logic [7:0]  CR_DIFB_RST  = 8'h00;
    localparam logic [7:0]  CR_FILT_RST  = 8'h00;
    localparam logic [7:0]  CR_GPIO_RST  = 8'h01;
    // Field positions.
    localparam int          SRST_BIT     = 7;
    localparam int          SHORT_BIT    = 3;
    localparam int          PORT_BIT     = 2;
    localparam int          TPAT_BIT     = 3;
    localparam int          DRV_LSB      = 4;
    localparam int          MLANE_BIT    = 0;
    localparam int          DCE_BIT      = 0;
    localparam int          SDO_EN_BIT   = 0;
    localparam logic [3:0]  DEC_MAX      = 4'hA;
    // Instruction lengths in bits, minus one.
    localparam logic [4:0]  INS_LONG_M1  = 5'hF;
    localparam logic [4:0]  INS_SHORT_M1 = 5'h7;
endpackage

// >>> hdl/aic_ser.sv
`timescale 1ns/1ps
module aic_ser (
    input  wire logic       clk,
    input  wire logic       rstn,
    aic_word_if.ser         w,
    output logic [3:0]      lane_bits
);
    import aic_pkg::*;

    typedef struct packed {
        logic        busy;
        logic [19:0] sh;
        logic [4:0]  left;
        logic [4:0]  cnt;
        logic [3:0]  bits;
    } aic_ser_s;

    aic_ser_s r;
    aic_ser_s next_r;
    logic     last;

    assign last    = r.busy && w.advance && (r.left == r.cnt);
    assign w.ready = !r.busy || last;

    always_comb begin
        next_r = r;
        if (r.busy && w.advance) begin
            next_r.sh   = r.sh << r.cnt;
            next_r.left = r.left - r.cnt;
            next_r.busy = !last;
        end
        if (w.valid && (!r.busy || last)) begin
            next_r.busy = 1'b1;
            next_r.sh   = w.data;
            next_r.left = WORD_BITS;
            next_r.cnt  = 5'h1 << w.lanes;
        end
        // Lane i carries bit 19-i of the current chunk, most significant first.
        for (int i = 0; i < 4; i++) begin
            next_r.bits[i] = next_r.busy && (5'(i) < next_r.cnt) && next_r.sh[19 - i];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign lane_bits = r.bits;
endmodule

// >>> hdl/aic_top.sv
`timescale 1ns/1ps
module aic_top (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic [7:0]                 paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [aic_pkg::SMP_W-1:0]  sample_in,
    input  wire logic                       sample_valid,
    input  wire logic                       convert_start_p,
    input  wire logic                       convert_start_n,
    output logic                            conv_go,
    input  wire logic                       cfg_cs_n,
    input  wire logic                       cfg_sclk,
    input  wire logic                       cfg_sdi,
    input  wire logic                       general_pin_zero_i,
    output logic                            general_pin_zero_o,
    output logic                            general_pin_zero_oe_n,
    input  wire logic                       ds_cs_n,
    input  wire logic                       ds_sclk,
    output logic      [3:0]                 sdp_lane,
    output logic      [1:0]                 dlane,
    output logic      [1:0]                 drive_str
);
    import aic_pkg::*;
    typedef struct packed {
        logic [7:0]  ifa, path, lane, difb, filt, gpio, wsh, rsh;
        logic [6:0]  s1, s2;
        logic        ck_prev, dsck_prev, cv_prev, difb_q, conv_go, in_data, is_rd, sdo, oe_n;
        logic        cv, fv, rd_pend, ov, pready, pslverr;
        logic [4:0]  bitcnt;
        logic [2:0]  dbit;
        logic [15:0] ish, gain;
        logic [14:0] addr, wptr, rptr;
        logic [19:0] corr, filt_w, od, offset, pattern;
        logic [29:0] acc;
        logic [10:0] fcnt;
        logic [31:0] prdata;
        logic [1:0]  dlane, drv;
        logic [3:0]  sdp;
    } aic_st_s;

    aic_st_s             r;
    aic_st_s             next_r;
    logic [SMP_W-1:0]    mem [0:(1 << BUF_AW) - 1];
    logic [SMP_W-1:0]    mem_q, src_d;
    logic                mem_we, src_v, cfg_wr, ck_rise, ck_fall, cv_lvl, port;
    logic [7:0]          wd;
    logic [1:0]          eff_path;
    logic [3:0]          dec, lane_bits;
    logic [10:0]         dec_mask;
    logic signed [20:0]  sum;
    logic signed [37:0]  prod;
    logic signed [29:0]  acc_n;

    aic_word_if wif ();
    aic_ser u_ser (
        .clk       (pclk),
        .rstn      (presetn),
        .w         (wif.ser),
        .lane_bits (lane_bits)
    );

    function automatic logic [7:0] cfg_rd(input logic [14:0] a, input aic_st_s s);
        case (a)
            CR_IFA:  cfg_rd = s.ifa;
            CR_PATH: cfg_rd = s.path;
            CR_LANE: cfg_rd = s.lane;
            CR_DIFB: cfg_rd = s.difb;
            CR_FILT: cfg_rd = s.filt;
            CR_GPIO: cfg_rd = s.gpio;
            default: cfg_rd = 8'h00;
        endcase
    endfunction

    assign ck_rise  = r.s2[1] && !r.ck_prev;
    assign ck_fall  = !r.s2[1] && r.ck_prev;
    assign cv_lvl   = r.difb[DCE_BIT] ? (r.s2[3] && !r.s2[4]) : r.s2[3];
    assign port     = r.path[PORT_BIT];
    assign eff_path = port ? {1'b1, r.path[0]} : r.path[1:0];
    assign dec      = (r.filt[3:0] > DEC_MAX) ? DEC_MAX : r.filt[3:0];
    assign dec_mask = (11'h1 << dec) - 11'h1;
    assign wd       = {r.wsh[6:0], r.s2[2]};
    assign src_v    = eff_path[0] ? r.fv : r.cv;
    assign src_d    = eff_path[0] ? r.filt_w : r.corr;
    assign sum      = signed'({sample_in[19], sample_in}) + signed'({r.offset[19], r.offset});
    assign prod     = sum * signed'({1'b0, r.gain});
    assign acc_n    = signed'(r.acc) + 30'(signed'(r.corr));
    assign mem_we   = eff_path[1] && src_v && (r.wptr != BUF_DEPTH);
    assign wif.valid   = r.ov;
    assign wif.data    = r.od;
    assign wif.lanes   = {port && r.lane[MLANE_BIT], !port && r.lane[MLANE_BIT]};
    assign wif.advance = port ? (!r.s2[5] && r.dsck_prev && !r.s2[6]) : 1'b1;

    always_comb begin
        next_r    = r;
        cfg_wr    = 1'b0;
        next_r.s1 = {ds_cs_n, ds_sclk, convert_start_n, convert_start_p,
                     cfg_sdi, cfg_sclk, cfg_cs_n};
        next_r.s2        = r.s1;
        next_r.ck_prev   = r.s2[1];
        next_r.dsck_prev = r.s2[5];
        next_r.cv_prev = cv_lvl;
        next_r.difb_q  = r.difb[DCE_BIT];
        next_r.conv_go = cv_lvl && !r.cv_prev && (r.difb_q == r.difb[DCE_BIT]);

        if (r.s2[0]) begin
            next_r.bitcnt  = 5'h0;
            next_r.dbit    = 3'h0;
            next_r.in_data = 1'b0;
            next_r.oe_n    = 1'b1;
        end else begin
            next_r.oe_n = !r.gpio[SDO_EN_BIT];
            if (ck_rise && !r.in_data) begin
                next_r.ish    = {r.ish[14:0], r.s2[2]};
                next_r.bitcnt = r.bitcnt + 5'h1;
                if (r.bitcnt == (r.ifa[SHORT_BIT] ? INS_SHORT_M1 : INS_LONG_M1)) begin
                    next_r.in_data = 1'b1;
                    next_r.is_rd   = r.ifa[SHORT_BIT] ? r.ish[6] : r.ish[14];
                    next_r.addr    = r.ifa[SHORT_BIT] ? {8'h00, r.ish[5:0], r.s2[2]}
                                                      : {r.ish[13:0], r.s2[2]};
                    next_r.rsh     = cfg_rd(next_r.addr, r);
                end
            end else if (ck_rise) begin
                next_r.wsh  = wd;
                next_r.dbit = r.dbit + 3'h1;
                if (r.dbit == 3'h7) begin
                    cfg_wr      = !r.is_rd;
                    next_r.addr = r.addr - 15'h1;
                    next_r.rsh  = cfg_rd(r.addr - 15'h1, r);
                end
            end
            if (ck_fall && r.in_data && r.is_rd) begin
                next_r.sdo = r.rsh[7];
                next_r.rsh = {r.rsh[6:0], 1'b0};
            end
        end

        if (cfg_wr) begin
            case (r.addr)
                CR_IFA:  next_r.ifa  = wd;
                CR_PATH: next_r.path = wd;
                CR_LANE: next_r.lane = wd;
                CR_DIFB: next_r.difb = wd;
                CR_FILT: next_r.filt = wd;
                CR_GPIO: next_r.gpio = wd;
                default: next_r.ifa  = r.ifa;
            endcase
            if (r.addr == CR_IFA && wd[SRST_BIT]) begin
                {next_r.ifa, next_r.path, next_r.lane} = {CR_IFA_RST, CR_PATH_RST, CR_LANE_RST};
                {next_r.difb, next_r.filt, next_r.gpio} = {CR_DIFB_RST, CR_FILT_RST, CR_GPIO_RST};
            end
        end

        next_r.cv = sample_valid;
        if (sample_valid) begin
            next_r.corr = prod[34:15];
        end
        next_r.fv = 1'b0;
        if (r.cv) begin
            if (r.fcnt == dec_mask) begin
                next_r.fv     = 1'b1;
                next_r.filt_w = 20'(acc_n >>> dec);
                next_r.acc    = 30'h0;
                next_r.fcnt   = 11'h0;
            end else begin
                next_r.acc  = acc_n;
                next_r.fcnt = r.fcnt + 11'h1;
            end
        end

        if (r.ov && wif.ready) begin
            next_r.ov = 1'b0;
        end
        if (!eff_path[1]) begin
            if (src_v && (!r.ov || wif.ready)) begin
                next_r.ov = 1'b1;
                next_r.od = r.path[TPAT_BIT] ? r.pattern : src_d;
            end
        end else if (r.wptr != BUF_DEPTH) begin
            if (mem_we) begin
                next_r.wptr = r.wptr + 15'h1;
            end
        end else if (r.rd_pend) begin
            next_r.ov      = 1'b1;
            next_r.od      = r.path[TPAT_BIT] ? r.pattern : mem_q;
            next_r.rd_pend = 1'b0;
            next_r.rptr    = r.rptr + 15'h1;
            if (r.rptr + 15'h1 == BUF_DEPTH) begin
                next_r.wptr = 15'h0;
                next_r.rptr = 15'h0;
            end
        end else if (!r.ov || wif.ready) begin
            next_r.rd_pend = 1'b1;
        end

        next_r.dlane = port ? 2'h0 : lane_bits[1:0];
        next_r.sdp   = port ? lane_bits : 4'h0;
        next_r.drv   = port ? 2'h0 : r.path[DRV_LSB +: 2];

        next_r.pready  = 1'b0;
        next_r.pslverr = 1'b0;
        if (psel && penable && !r.pready) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            case (paddr)
                A_OFFSET:  next_r.prdata = {12'h000, r.offset};
                A_GAIN:    next_r.prdata = {16'h0000, r.gain};
                A_PATTERN: next_r.prdata = {12'h000, r.pattern};
                A_STATUS:  next_r.prdata = {12'h000, r.difb[DCE_BIT], port, eff_path,
                                            r.rd_pend, r.wptr};
                default:   next_r.pslverr = 1'b1;
            endcase
        end
        // Writes land at the edge on which the master sees pready high.
        if (psel && penable && r.pready && pwrite) begin
            case (paddr)
                A_OFFSET:  next_r.offset  = pwdata[19:0];
                A_GAIN:    next_r.gain    = pwdata[15:0];
                A_PATTERN: next_r.pattern = pwdata[19:0];
                default:   next_r.offset  = r.offset;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r         <= '0;
            {r.ifa, r.path, r.lane}       <= {CR_IFA_RST, CR_PATH_RST, CR_LANE_RST};
            {r.difb, r.filt, r.gpio}      <= {CR_DIFB_RST, CR_FILT_RST, CR_GPIO_RST};
            {r.s1, r.s2}                  <= {7'h63, 7'h63};
            r.ck_prev                     <= 1'b1;
            r.oe_n                        <= 1'b1;
            {r.offset, r.gain, r.pattern} <= {OFFSET_RST, GAIN_RST, PATTERN_RST};
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[r.wptr[BUF_AW-1:0]] <= src_d;
        end
        mem_q <= mem[r.rptr[BUF_AW-1:0]];
    end

    assign prdata                = r.prdata;
    assign pready                = r.pready;
    assign pslverr               = r.pslverr;
    assign conv_go               = r.conv_go;
    assign general_pin_zero_o    = r.sdo;
    assign general_pin_zero_oe_n = r.oe_n;
    assign sdp_lane              = r.sdp;
    assign dlane                 = r.dlane;
    assign drive_str             = r.drv;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_CONV_EDGE: assert property (
        (!r.difb[DCE_BIT] && !r.difb_q && $rose(convert_start_p)) ##1 !r.difb[DCE_BIT] [*2]
        |=> conv_go) else $error("convert-start edge gave no conversion");
    AST_MODE_DEF: assert property (
        $rose(r.difb[DCE_BIT]) |-> $past(cfg_wr)) else $error("mode left default without write");
    AST_DIFF_WR: assert property (
        (cfg_wr && r.addr == CR_DIFB && wd[DCE_BIT]) |=> r.difb[DCE_BIT])
        else $error("differential enable write not taken");
    AST_PORT_DEF: assert property (
        $rose(r.path[PORT_BIT]) |-> $past(cfg_wr)) else $error("port changed without write");
    AST_STREAM: assert property (
        (r.cv && eff_path == 2'h0 && !r.path[TPAT_BIT] && (!r.ov || wif.ready))
        |=> r.ov && r.od == $past(r.corr)) else $error("raw result not streamed");
    AST_BUF_LIMIT: assert property (
        mem_we |=> (r.wptr == $past(r.wptr) + 15'h1) && (r.wptr <= BUF_DEPTH))
        else $error("buffer pointer wrong");
    AST_NO_STREAM: assert property (
        (port && $rose(r.ov)) |-> $past(r.rd_pend)) else $error("serial port streamed directly");
    AST_DRIVE: assert property (
        port |=> drive_str == 2'h0) else $error("drive strength on serial port");
    AST_INS_LEN: assert property (
        (ck_rise && !r.s2[0] && !r.in_data && r.bitcnt == (r.ifa[SHORT_BIT] ? 5'h7 : 5'hF))
        |=> r.in_data) else $error("instruction length wrong");
    AST_SDO_EDGE: assert property (
        $changed(r.sdo) |-> $past(ck_fall)) else $error("read data changed off falling edge");
    AST_SDO_PIN: assert property (
        (!r.s2[0] && r.gpio[SDO_EN_BIT]) |=> !general_pin_zero_oe_n)
        else $error("pin zero not driven during frame");
    AST_MODE_GAP: assert property (
        (r.difb_q != r.difb[DCE_BIT]) |=> !conv_go) else $error("edge from mode change");
    COV_CONV:  cover property (conv_go);
    COV_FULL:  cover property (r.wptr == BUF_DEPTH);
    COV_DIFB:  cover property (cfg_wr && r.addr == CR_DIFB);
    COV_SPORT: cover property (port && r.ov && wif.ready);
endmodule

// >>> hdl/aic_word_if.sv
`timescale 1ns/1ps
interface aic_word_if;
    logic        valid;
    logic        ready;
    logic        advance;
    logic [19:0] data;
    logic [1:0]  lanes;
    modport src (output valid, output data, output lanes, output advance, input ready);
    modport ser (input valid, input data, input lanes, input advance, output ready);
endinterface

// >>> sim/adc_interface_conversion_control_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end
module adc_interface_conversion_control_bench;
    import aic_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [19:0] sample_in, ofs;
    logic        conv_go, cs_n, sclk, sdi, cp, cn, pin_i, pin_o, pin_oe_n, ds_cs_n, ds_sclk, er;
    logic [3:0]  sdp_lane;
    logic [1:0]  dlane, drive_str;
    logic [7:0]  rb;
    logic        short_m = 1'b0;
    int          err_total = 0;
    int          tests_run = 0;
    int          go_cnt = 0;
    int          g;
    aic_top i_aic_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
        .sample_valid(sample_valid), .convert_start_p(cp), .convert_start_n(cn),
        .conv_go(conv_go), .cfg_cs_n(cs_n), .cfg_sclk(sclk), .cfg_sdi(sdi),
        .general_pin_zero_i(pin_i), .general_pin_zero_o(pin_o),
        .general_pin_zero_oe_n(pin_oe_n), .ds_cs_n(ds_cs_n), .ds_sclk(ds_sclk),
        .sdp_lane(sdp_lane), .dlane(dlane), .drive_str(drive_str));
    aic_host_model i_aic_host_model (.pclk(pclk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .pin_w(pin_i), .cfg_cs_n(cs_n), .cfg_sclk(sclk), .cfg_sdi(sdi), .cnv_p(cp),
        .cnv_n(cn));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(negedge pclk) if (conv_go === 1'b1) go_cnt++;
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 40) begin
            err_total++;
            end_sim();
        end
    endtask
    task automatic cw(input logic [14:0] a, input logic [7:0] d);
        i_aic_host_model.frame(1'b0, a, short_m, d, rb);
    endtask
    task automatic cr(input logic [14:0] a);
        i_aic_host_model.frame(1'b1, a, short_m, 8'h00, rb);
    endtask
    function automatic logic [31:0] rst_val(input int i);
        case (i)
            0: return {12'h000, OFFSET_RST};
            1: return {16'h0000, GAIN_RST};
            2: return {12'h000, PATTERN_RST};
            default: return 32'h0000_0000;
        endcase
    endfunction
    function automatic logic lane_bit(input logic [19:0] s, input int nl, input int k,
                                      input int i);
        return s[19 - nl * k - i];
    endfunction
    function automatic logic [19:0] exp_word(input logic [19:0] s, input logic tp);
        return tp ? PATTERN_RST : s + ofs;
    endfunction
    task automatic stream(input int nl, input logic tp);
        logic [19:0] s;
        logic [19:0] e;
        s = 20'($urandom());
        e = exp_word(s, tp);
        sample_in    <= s;
        sample_valid <= 1'b1;
        @(posedge pclk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge pclk);
        for (int k = 0; k < 20 / nl; k++) begin
            @(negedge pclk);
            for (int i = 0; i < nl; i++) `CHK(dlane[i], lane_bit(e, nl, k, i))
            @(posedge pclk);
        end
    endtask
    initial begin
        void'($urandom(32'hc0129862));
        presetn      = 1'b0;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 8'h00;
        pwdata       = 32'h0000_0000;
        sample_in    = 20'h0_0000;
        sample_valid = 1'b0;
        ds_cs_n      = 1'b1;
        ds_sclk      = 1'b1;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        `CHK(pin_oe_n, 1'b1)
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK(rd, rst_val(i))
        end
        apb(1'b0, 8'h10, 32'h0);
        `CHK({er, rd}, 33'h1_0000_0000)
        cr(CR_GPIO);
        `CHK(rb, CR_GPIO_RST)
        g = go_cnt;
        i_aic_host_model.pulse(1'b1);
        `CHK(go_cnt - g, 1)
        cw(CR_DIFB, 8'h01);
        apb(1'b0, A_STATUS, 32'h0);
        `CHK(rd[19], 1'b1)
        g = go_cnt;
        i_aic_host_model.pulse(1'b1);
        i_aic_host_model.pulse(1'b0);
        `CHK(go_cnt - g, 1)
        cr(CR_DIFB);
        `CHK(rb, 8'h01)
        ofs = 20'($urandom());
        apb(1'b1, A_OFFSET, {12'h000, ofs});
        apb(1'b0, A_OFFSET, 32'h0000_0000);
        `CHK(rd, {12'h000, ofs})
        for (int nl = 1; nl <= 2; nl++) begin
            cw(CR_LANE, 8'(nl - 1));
            stream(nl, 1'b0);
        end
        cw(CR_PATH, 8'h08);
        stream(2, 1'b1);
        `CHK(sdp_lane, 4'h0)
        for (int p = 0; p < 4; p++) begin
            cw(CR_PATH, 8'(p) | 8'h20);
            apb(1'b0, A_STATUS, 32'h0);
            `CHK(rd[17:16], 2'(p))
            `CHK(drive_str, 2'h2)
        end
        cw(CR_PATH, 8'h24);
        apb(1'b0, A_STATUS, 32'h0);
        `CHK(rd[18:16], 3'h6)
        `CHK({drive_str, dlane}, 4'h0)
        cw(CR_LANE, 8'h00);
        cw(CR_IFA, 8'h08);
        short_m = 1'b1;
        cw(CR_LANE, 8'h01);
        cr(CR_LANE);
        `CHK(rb, 8'h01)
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        short_m = 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, A_STATUS, 32'h0);
        `CHK(rd, 32'h0000_0000)
        cw(CR_PATH, 8'h02);
        sample_valid <= 1'b1;
        for (int i = 0; i < 16384; i++) begin
            sample_in <= 20'($urandom());
            @(posedge pclk);
        end
        sample_valid <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, A_STATUS, 32'h0);
        `CHK(rd[14:0], BUF_DEPTH)
        end_sim();
    end
endmodule

// >>> sim/aic_host_model.sv
`timescale 1ns/1ps
module aic_host_model (
    input  wire logic pclk,
    input  wire logic pin_o,
    input  wire logic pin_oe_n,
    output logic      pin_w,
    output logic      cfg_cs_n,
    output logic      cfg_sclk,
    output logic      cfg_sdi,
    output logic      cnv_p,
    output logic      cnv_n
);
    // A released pin zero has no pull, so it shows a level that keeps changing.
    assign pin_w = pin_oe_n ? ~pclk : pin_o;
    initial begin
        cfg_cs_n = 1'b1;
        cfg_sclk = 1'b1;
        cfg_sdi  = 1'b0;
        cnv_p    = 1'b0;
        cnv_n    = 1'b0;
    end
    task automatic frame(input logic rd, input logic [14:0] a, input logic sh,
                         input logic [7:0] wb, output logic [7:0] rb);
        logic [23:0] bits;
        int          nb;
        nb   = sh ? 16 : 24;
        bits = sh ? {rd, a[6:0], wb, 8'h00} : {rd, a, wb};
        cfg_cs_n <= 1'b0;
        repeat (4) @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
            cfg_sclk <= 1'b0;
            cfg_sdi  <= bits[23-i];
            repeat (4) @(posedge pclk);
            cfg_sclk <= 1'b1;
            @(negedge pclk);
            rb = {rb[6:0], pin_w};
            repeat (4) @(posedge pclk);
        end
        cfg_cs_n <= 1'b1;
        cfg_sdi  <= ~bits[24-nb];
        repeat (8) @(posedge pclk);
    endtask
    task automatic pulse(input logic nlev);
        cnv_n <= nlev;
        repeat (3) @(posedge pclk);
        cnv_p <= 1'b1;
        repeat (4) @(posedge pclk);
        cnv_p <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
endmodule
